//--- hw/srpc_defines.svh
// Register map, field positions, reset values and timing constants of the reset/power control block
`ifndef SRPC_DEFINES_SVH
`define SRPC_DEFINES_SVH

// Management register addresses
`define SRPC_ADDR_IRQ_STATUS 16'h0010
`define SRPC_ADDR_IRQ_MASK 16'h0020
`define SRPC_ADDR_SFT_RST 16'h8810
`define SRPC_ADDR_SFT_PD 16'h8812
`define SRPC_ADDR_PHY_RST 16'h8814
`define SRPC_ADDR_MAC_RST 16'h8815
`define SRPC_ADDR_STAT 16'h8818
`define SRPC_ADDR_PMG 16'h8819
`define SRPC_ADDR_DIAG 16'h882c

// Field positions
`define SRPC_BIT_SW_IRQ 15
`define SRPC_BIT_HRD_IRQ 12
`define SRPC_EVT_W 12
`define SRPC_BIT_CTRL 0
`define SRPC_BIT_SYS_RDY 0
`define SRPC_BIT_PD_RDY 1
`define SRPC_BIT_DIAG_RSVD 1

// Reset values
`define SRPC_RST_IRQ_STATUS 16'h1000
`define SRPC_RST_IRQ_MASK 16'h1bfe
`define SRPC_RST_DIAG 16'h0002

// Timing: figures in ns, cycle counts derived from the 25 ns clock, least times rounded up
`define SRPC_CLK_PERIOD_NS 25
`define SRPC_STARTUP_TIME_NS 2000
`define SRPC_RST_PULSE_TIME_NS 200
`define SRPC_STARTUP_CYC ((`SRPC_STARTUP_TIME_NS + `SRPC_CLK_PERIOD_NS - 1) / `SRPC_CLK_PERIOD_NS)
`define SRPC_RST_PULSE_CYC ((`SRPC_RST_PULSE_TIME_NS + `SRPC_CLK_PERIOD_NS - 1) / `SRPC_CLK_PERIOD_NS)

`endif

//--- hw/srpc_pkg.sv
// Types shared by the reset/power control block
package srpc_pkg;
	typedef enum logic {SRPC_BOOT, SRPC_READY} srpc_state_t;
endpackage : srpc_pkg

//--- hw/srpc_sc_pulse.sv
// Self-clearing reset request: holds busy for a fixed number of cycles after a start
`timescale 1ns/1ps
`default_nettype none
module srpc_sc_pulse #(
	parameter int CYCLES = 8
) (
	input wire logic clk, // Device clock
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic start, // One-cycle request
	output logic busy // High while the reset is applied
);
	logic [15:0] cnt;
	logic cnt_last;

	assign cnt_last = (cnt == 16'h0001);

	// A start while busy is ignored so the reset length never stretches unbounded
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy <= 1'b0;
			cnt <= 16'h0000;
		end else if (!busy && start) begin
			busy <= 1'b1;
			cnt <= 16'(CYCLES);
		end else if (busy) begin
			busy <= !cnt_last;
			cnt <= cnt - 16'h0001;
		end
	end
endmodule : srpc_sc_pulse
`default_nettype wire

//--- hw/srpc_sync2.sv
// Two-flop synchroniser for a level arriving from a pin
`timescale 1ns/1ps
`default_nettype none
module srpc_sync2 (
	input wire logic clk, // Device clock
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic d, // Asynchronous level
	output logic q // Synchronised level
);
	logic meta;

	// First flop feeds only the second one
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= 1'b0;
			q <= 1'b0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : srpc_sync2
`default_nettype wire

//--- hw/srpc_top.sv
// Chip reset, power-down and clock control with its management registers
`timescale 1ns/1ps
`default_nettype none
`include "srpc_defines.svh"
module srpc_top #(
	parameter int STARTUP_CYCLES = `SRPC_STARTUP_CYC,
	parameter int RST_PULSE_CYCLES = `SRPC_RST_PULSE_CYC
) (
	input wire logic clk, // Device clock, 40 MHz
	input wire logic sys_rst, // Hardware reset, async, active high
	input wire logic [15:0] mgmt_addr, // Management register address
	input wire logic [15:0] mgmt_wdata, // Management write data
	input wire logic mgmt_wr, // One-cycle write strobe
	input wire logic mgmt_rd, // One-cycle read strobe
	input wire logic [11:0] sys_event, // Other system event pulses, same clock
	input wire logic power_down_strap_pin, // Strap pin, asynchronous
	output logic [15:0] mgmt_rdata, // Read data, valid with mgmt_rvalid
	output logic mgmt_rvalid, // Read answer pulse
	output logic irq_out, // System interrupt, active high
	output logic chip_soft_reset, // Full-chip soft reset, active high
	output logic phy_subsys_reset, // PHY subsystem reset, active high
	output logic mac_if_reset, // PHY-to-MAC interface reset, active high
	output logic power_down, // Low power mode request
	output logic boot_osc_force_on, // Keep boot oscillator running
	output logic diag_clk_run, // Diagnostics clock gate enable
	output logic system_ready_flag // Start-up complete
);
	import srpc_pkg::*;

	localparam int PULSE_MAX = RST_PULSE_CYCLES + 1;
	localparam int BOOT_MAX = STARTUP_CYCLES + 1;

	srpc_state_t state;
	logic [15:0] boot_cnt;
	logic strap_sync;
	logic mask_hrd_en;
	logic [`SRPC_EVT_W-1:0] mask_evt;
	logic stat_sw;
	logic stat_hrd;
	logic [`SRPC_EVT_W-1:0] stat_evt;
	logic diag_rsvd;

	// Address decode
	wire sel_stat_irq = (mgmt_addr == `SRPC_ADDR_IRQ_STATUS);
	wire sel_mask = (mgmt_addr == `SRPC_ADDR_IRQ_MASK);
	wire sel_sft_rst = (mgmt_addr == `SRPC_ADDR_SFT_RST);
	wire sel_sft_pd = (mgmt_addr == `SRPC_ADDR_SFT_PD);
	wire sel_phy = (mgmt_addr == `SRPC_ADDR_PHY_RST);
	wire sel_mac = (mgmt_addr == `SRPC_ADDR_MAC_RST);
	wire sel_stat = (mgmt_addr == `SRPC_ADDR_STAT);
	wire sel_pmg = (mgmt_addr == `SRPC_ADDR_PMG);
	wire sel_diag = (mgmt_addr == `SRPC_ADDR_DIAG);

	// Accesses are never gated by power-down; writes are gated by the soft reset, power-down writes also by start-up
	wire wr_ok = mgmt_wr && !chip_soft_reset;
	wire wr_mask = wr_ok && sel_mask;
	wire wr_pd = wr_ok && sel_sft_pd && (state == SRPC_READY);
	wire wr_pmg = wr_ok && sel_pmg;
	wire wr_diag = wr_ok && sel_diag;
	wire rd_stat_irq = mgmt_rd && sel_stat_irq;

	// Only a one in the control bit starts a self-clearing reset
	wire start_sft = wr_ok && sel_sft_rst && mgmt_wdata[`SRPC_BIT_CTRL];
	wire start_phy = wr_ok && sel_phy && mgmt_wdata[`SRPC_BIT_CTRL];
	wire start_mac = wr_ok && sel_mac && mgmt_wdata[`SRPC_BIT_CTRL];
	wire sw_irq_req = wr_mask && mgmt_wdata[`SRPC_BIT_SW_IRQ];
	wire soft_boot = start_sft || chip_soft_reset; // Ready drops together with the soft reset output, not one cycle after it

	// Interrupt gating; the software request has no mask bit of its own
	wire [`SRPC_EVT_W-1:0] evt_masked = stat_evt & mask_evt;
	wire next_irq = stat_sw | (stat_hrd & mask_hrd_en) | (|evt_masked);

	// Read data; request bit and reserved bits read zero, diag reserved bit reads its reset value
	wire [15:0] rd_mask = {1'b0, 2'b00, mask_hrd_en, mask_evt};
	wire [15:0] rd_irq = {stat_sw, 2'b00, stat_hrd, stat_evt};
	wire [15:0] rd_stat = {14'h0000, power_down, system_ready_flag};
	wire [15:0] rd_sc_sft = {15'h0000, chip_soft_reset};
	wire [15:0] rd_sc_phy = {15'h0000, phy_subsys_reset};
	wire [15:0] rd_sc_mac = {15'h0000, mac_if_reset};
	wire [15:0] rd_pd = {15'h0000, power_down};
	wire [15:0] rd_pmg = {15'h0000, boot_osc_force_on};
	wire [15:0] rd_diag = {14'h0000, diag_rsvd, diag_clk_run};
	wire [15:0] rd_mux = sel_stat_irq ? rd_irq :
		sel_mask ? rd_mask :
		sel_sft_rst ? rd_sc_sft :
		sel_sft_pd ? rd_pd :
		sel_phy ? rd_sc_phy :
		sel_mac ? rd_sc_mac :
		sel_stat ? rd_stat :
		sel_pmg ? rd_pmg :
		sel_diag ? rd_diag : 16'h0000;

	wire boot_done = (boot_cnt == 16'h0001);
	// Reset values as constants so the asynchronous reset branches load constants only
	localparam logic [15:0] diag_rst = `SRPC_RST_DIAG;
	localparam logic [15:0] mask_rst = `SRPC_RST_IRQ_MASK;
	localparam logic [15:0] irq_rst = `SRPC_RST_IRQ_STATUS;

	// Strap pin crosses in through two flops
	srpc_sync2 u_strap_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(power_down_strap_pin),
		.q(strap_sync)
	);

	// Self-clearing reset requests: whole chip, PHY subsystem, PHY-to-MAC interface
	srpc_sc_pulse #(.CYCLES(RST_PULSE_CYCLES)) u_sft_rst (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(start_sft),
		.busy(chip_soft_reset)
	);

	srpc_sc_pulse #(.CYCLES(RST_PULSE_CYCLES)) u_phy_rst (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(start_phy),
		.busy(phy_subsys_reset)
	);

	srpc_sc_pulse #(.CYCLES(RST_PULSE_CYCLES)) u_mac_rst (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(start_mac),
		.busy(mac_if_reset)
	);

	// Start-up sequence, restarted by hardware or soft reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= SRPC_BOOT;
			boot_cnt <= 16'(STARTUP_CYCLES);
			system_ready_flag <= 1'b0;
		end else if (soft_boot) begin
			state <= SRPC_BOOT;
			boot_cnt <= 16'(STARTUP_CYCLES);
			system_ready_flag <= 1'b0;
		end else begin
			case (state)
				SRPC_BOOT: begin
					boot_cnt <= boot_cnt - 16'h0001;
					if (boot_done) begin
						state <= SRPC_READY;
						system_ready_flag <= 1'b1;
					end
				end
				SRPC_READY: begin
					boot_cnt <= boot_cnt;
				end
				default: begin
					state <= SRPC_BOOT;
				end
			endcase
		end
	end

	// Ready must already be low in the cycle after the soft reset request
	a_ready_drop: assert property (@(posedge clk) disable iff (sys_rst)
		start_sft |=> !system_ready_flag)
		else $error("system ready still shown after a software reset request");

	// Power-down follows the strap during start-up so the chip can wake already powered down
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			power_down <= 1'b0;
		end else if (state == SRPC_BOOT) begin
			power_down <= strap_sync;
		end else if (wr_pd) begin
			power_down <= mgmt_wdata[`SRPC_BIT_CTRL];
		end
	end

	// Strap is followed while booting, software takes over once ready
	a_pd_strap_boot: assert property (@(posedge clk) disable iff (sys_rst)
		(state == SRPC_BOOT) |=> (power_down == $past(strap_sync)))
		else $error("power-down did not follow the strap during start-up");
	a_pd_write: assert property (@(posedge clk) disable iff (sys_rst)
		wr_pd |=> (power_down == $past(mgmt_wdata[`SRPC_BIT_CTRL])))
		else $error("power-down bit did not take the written value");

	// Clock controls; soft reset returns them to their reset values
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			boot_osc_force_on <= 1'b0;
			diag_clk_run <= diag_rst[`SRPC_BIT_CTRL];
			diag_rsvd <= diag_rst[`SRPC_BIT_DIAG_RSVD];
		end else if (chip_soft_reset) begin
			boot_osc_force_on <= 1'b0;
			diag_clk_run <= diag_rst[`SRPC_BIT_CTRL];
			diag_rsvd <= diag_rst[`SRPC_BIT_DIAG_RSVD];
		end else begin
			if (wr_pmg)
				boot_osc_force_on <= mgmt_wdata[`SRPC_BIT_CTRL];
			if (wr_diag)
				diag_clk_run <= mgmt_wdata[`SRPC_BIT_CTRL];
		end
	end

	// Both clock controls take a write and fall back to their reset values under soft reset
	a_osc_write: assert property (@(posedge clk) disable iff (sys_rst)
		wr_pmg |=> (boot_osc_force_on == $past(mgmt_wdata[`SRPC_BIT_CTRL])))
		else $error("force-oscillator bit did not take the written value");
	a_diag_write: assert property (@(posedge clk) disable iff (sys_rst)
		wr_diag |=> (diag_clk_run == $past(mgmt_wdata[`SRPC_BIT_CTRL])))
		else $error("diagnostics clock enable did not take the written value");
	a_clk_soft_rst: assert property (@(posedge clk) disable iff (sys_rst)
		chip_soft_reset |=> (!boot_osc_force_on && !diag_clk_run))
		else $error("clock controls not restored by the software reset");

	// Mask register; the hardware reset enable is only reloaded by the hardware reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_hrd_en <= mask_rst[`SRPC_BIT_HRD_IRQ];
			mask_evt <= mask_rst[`SRPC_EVT_W-1:0];
		end else if (chip_soft_reset) begin
			mask_evt <= mask_rst[`SRPC_EVT_W-1:0];
		end else if (wr_mask) begin
			mask_hrd_en <= mgmt_wdata[`SRPC_BIT_HRD_IRQ];
			mask_evt <= mgmt_wdata[`SRPC_EVT_W-1:0];
		end
	end

	// Latched status, cleared by reading; a new event in the read cycle wins
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_sw <= irq_rst[`SRPC_BIT_SW_IRQ];
			stat_hrd <= irq_rst[`SRPC_BIT_HRD_IRQ];
			stat_evt <= irq_rst[`SRPC_EVT_W-1:0];
		end else begin
			stat_sw <= sw_irq_req | (stat_sw & !rd_stat_irq);
			stat_hrd <= stat_hrd & !rd_stat_irq;
			stat_evt <= sys_event | (stat_evt & {`SRPC_EVT_W{!rd_stat_irq}});
		end
	end

	// A read with no new request empties the software status bit
	a_sw_stat_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(rd_stat_irq && !sw_irq_req) |=> !stat_sw)
		else $error("software interrupt status not cleared by a read");

	// Interrupt output and read answer, both registered
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_out <= 1'b0;
			mgmt_rdata <= 16'h0000;
			mgmt_rvalid <= 1'b0;
		end else begin
			irq_out <= next_irq;
			mgmt_rvalid <= mgmt_rd;
			mgmt_rdata <= mgmt_rd ? rd_mux : 16'h0000;
		end
	end

	// Every read is answered one cycle later, power-down or not
	a_rd_answer: assert property (@(posedge clk) disable iff (sys_rst)
		mgmt_rd |=> mgmt_rvalid)
		else $error("read strobe not answered");

	// Checks
	a_sw_irq_set: assert property (@(posedge clk) disable iff (sys_rst)
		sw_irq_req |=> stat_sw ##1 irq_out)
		else $error("software interrupt request not latched and signalled");
	a_mask_rd_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(mgmt_rd && sel_mask) |=> (mgmt_rvalid && !mgmt_rdata[`SRPC_BIT_SW_IRQ]))
		else $error("software interrupt request bit read back as one");
	a_hrd_irq_out: assert property (@(posedge clk) disable iff (sys_rst)
		(stat_hrd && mask_hrd_en) |=> irq_out)
		else $error("enabled hardware reset interrupt not signalled");
	a_hrd_en_drop: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(mask_hrd_en) |-> $past(wr_mask && !mgmt_wdata[`SRPC_BIT_HRD_IRQ]))
		else $error("hardware reset interrupt enable cleared without a write");
	a_sft_rst_clear: assert property (@(posedge clk) disable iff (sys_rst)
		start_sft |=> chip_soft_reset ##[1:PULSE_MAX] !chip_soft_reset)
		else $error("software reset bit did not self clear in time");
	a_phy_rst_clear: assert property (@(posedge clk) disable iff (sys_rst)
		start_phy |=> phy_subsys_reset ##[1:PULSE_MAX] !phy_subsys_reset)
		else $error("PHY subsystem reset bit did not self clear in time");
	a_mac_rst_clear: assert property (@(posedge clk) disable iff (sys_rst)
		start_mac |=> mac_if_reset ##[1:PULSE_MAX] !mac_if_reset)
		else $error("PHY-to-MAC interface reset bit did not self clear in time");
	a_pd_status_rd: assert property (@(posedge clk) disable iff (sys_rst)
		(mgmt_rd && sel_stat) |=> (mgmt_rdata[`SRPC_BIT_PD_RDY] == $past(power_down)))
		else $error("power-down status does not match power-down state");
	a_ready_boot: assert property (@(posedge clk) disable iff (sys_rst)
		(state == SRPC_BOOT) |-> !system_ready_flag)
		else $error("system ready shown during start-up");
	a_ready_bound: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(chip_soft_reset) |-> ##[1:BOOT_MAX] system_ready_flag)
		else $error("start-up did not complete in time");
	a_status_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(stat_hrd && !rd_stat_irq) |=> stat_hrd)
		else $error("latched status lost without a read");
	a_zero_wr_none: assert property (@(posedge clk) disable iff (sys_rst)
		(mgmt_wr && sel_phy && !mgmt_wdata[`SRPC_BIT_CTRL] && !phy_subsys_reset) |=> !phy_subsys_reset)
		else $error("zero write started a PHY subsystem reset");
	a_pd_in_reg: assert property (@(posedge clk) disable iff (sys_rst)
		(wr_pmg && power_down) |=> (boot_osc_force_on == $past(mgmt_wdata[`SRPC_BIT_CTRL])))
		else $error("register write lost during power-down");
endmodule : srpc_top
`default_nettype wire

//--- testbench/srpc_host_model.sv
// Management host model that issues register reads and writes
`timescale 1ns/1ps
`default_nettype none
module srpc_host_model (
	input wire logic clk, // Device clock
	input wire logic [15:0] mgmt_rdata, // Read data from the device
	input wire logic mgmt_rvalid, // Read answer pulse
	output logic [15:0] mgmt_addr, // Register address
	output logic [15:0] mgmt_wdata, // Write data
	output logic mgmt_wr, // Write strobe
	output logic mgmt_rd // Read strobe
);
	// Quiet bus at time zero; the two strobes are never raised together
	initial begin
		mgmt_addr = 16'h0000;
		mgmt_wdata = 16'h0000;
		mgmt_wr = 1'b0;
		mgmt_rd = 1'b0;
	end

	// One-cycle write, launched on a falling edge and taken at the next rising edge
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		mgmt_addr = a;
		mgmt_wdata = d;
		mgmt_wr = 1'b1;
		@(negedge clk);
		mgmt_wr = 1'b0;
		mgmt_addr = ~a; // Released lines show a fresh pattern, not the old value
		mgmt_wdata = ~d;
	endtask : wr

	// One-cycle read; the answer is taken in the cycle its valid pulse stands
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge clk);
		mgmt_addr = a;
		mgmt_rd = 1'b1;
		@(negedge clk);
		mgmt_rd = 1'b0;
		mgmt_addr = ~a;
		d = mgmt_rvalid ? mgmt_rdata : 16'hxxxx; // A missing answer can never match
	endtask : rd
endmodule : srpc_host_model
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the reset, power-down and clock control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int SU = 4;
	localparam int RP = 2;
	typedef struct {logic [15:0] a; logic [15:0] e;} srpc_row_t;
	logic clk, sys_rst, mgmt_wr, mgmt_rd, mgmt_rvalid, power_down_strap_pin;
	logic irq_out, chip_soft_reset, phy_subsys_reset, mac_if_reset, power_down;
	logic boot_osc_force_on, diag_clk_run, system_ready_flag;
	logic [15:0] mgmt_addr, mgmt_wdata, mgmt_rdata, rv;
	logic [11:0] sys_event;
	int num_errors = 0;
	int n_tests = 0;
	srpc_row_t rows[11] = '{'{16'h0010, 16'h1000}, '{16'h0010, 16'h0000}, '{16'h0020, 16'h1bfe},
		'{16'h8810, 16'h0000}, '{16'h8812, 16'h0000}, '{16'h8814, 16'h0000}, '{16'h8815, 16'h0000},
		'{16'h8818, 16'h0001}, '{16'h8819, 16'h0000}, '{16'h882c, 16'h0002}, '{16'h1234, 16'h0000}};
	logic [15:0] msk[3] = '{16'h1000, 16'h1020, 16'h1fff};
	logic [11:0] ev[3] = '{12'h020, 12'h020, 12'hfff};
	logic [15:0] ra[2] = '{16'h8814, 16'h8815};
	// All level outputs in one word: bit0 interrupt up to bit7 ready
	wire [15:0] outs = {8'h00, system_ready_flag, diag_clk_run, boot_osc_force_on, power_down,
		mac_if_reset, phy_subsys_reset, chip_soft_reset, irq_out};

	srpc_top #(.STARTUP_CYCLES(SU), .RST_PULSE_CYCLES(RP)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
		.sys_event(sys_event), .power_down_strap_pin(power_down_strap_pin), .mgmt_rdata(mgmt_rdata),
		.mgmt_rvalid(mgmt_rvalid), .irq_out(irq_out), .chip_soft_reset(chip_soft_reset),
		.phy_subsys_reset(phy_subsys_reset), .mac_if_reset(mac_if_reset), .power_down(power_down),
		.boot_osc_force_on(boot_osc_force_on), .diag_clk_run(diag_clk_run),
		.system_ready_flag(system_ready_flag));
	srpc_host_model u_host (.clk(clk), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
		.mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd));

	// 40 MHz device clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic rchk(input logic [15:0] a, input logic [15:0] e);
		u_host.rd(a, rv);
		check(rv, e);
	endtask : rchk

	// Hardware reset held three cycles; every level output must sit low inside it
	task automatic hw_reset;
		sys_rst = 1'b1;
		repeat (3) @(negedge clk);
		check(outs, 16'h0000);
		sys_rst = 1'b0;
	endtask : hw_reset

	task automatic wrap_up;
		$display("checks=%0d errors=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	// Main sequence: reset values by table, then the awkward cases by hand
	initial begin
		sys_event = 12'h000;
		power_down_strap_pin = 1'b0;
		hw_reset();
		@(negedge clk);
		check(outs, 16'h0001);
		repeat (SU - 2) @(negedge clk);
		check(outs, 16'h0001);
		@(negedge clk);
		check(outs, 16'h0081);
		foreach (rows[i]) rchk(rows[i].a, rows[i].e);
		@(negedge clk);
		check(outs, 16'h0080);
		// Software interrupt request cannot be masked and never reads back
		u_host.wr(16'h0020, 16'h9bfe);
		@(negedge clk);
		check(outs, 16'h0081);
		rchk(16'h0020, 16'h1bfe);
		rchk(16'h0010, 16'h8000);
		@(negedge clk);
		check(outs, 16'h0080);
		// Events latch whatever the mask; only enabled ones reach the interrupt
		foreach (msk[i]) begin
			u_host.wr(16'h0020, msk[i]);
			@(negedge clk) sys_event = ev[i];
			@(negedge clk) sys_event = 12'h000;
			@(negedge clk);
			check(outs, (i == 0) ? 16'h0080 : 16'h0081);
			rchk(16'h0010, {4'h0, ev[i]});
			@(negedge clk);
		end
		// Self-clearing local resets: zero writes idle, one writes pulse only their own output
		for (int i = 0; i < 2; i++) begin
			u_host.wr(ra[i], 16'h0000);
			check(outs, 16'h0080);
			u_host.wr(ra[i], 16'h0001);
			check(outs, 16'h0080 | (16'h0004 << i));
			repeat (RP) @(negedge clk);
			check(outs, 16'h0080);
			rchk(ra[i], 16'h0000);
		end
		u_host.wr(16'h8818, 16'hffff);
		rchk(16'h8818, 16'h0001);
		u_host.wr(16'h8819, 16'hfffe);
		rchk(16'h8819, 16'h0000);
		u_host.wr(16'h8819, 16'h0001);
		u_host.wr(16'h882c, 16'h0001);
		check(outs, 16'h00e0);
		rchk(16'h882c, 16'h0003);
		rchk(16'h8819, 16'h0001);
		// Software reset drops ready and restores the clock controls
		u_host.wr(16'h8810, 16'h0001);
		check(outs & 16'h0082, 16'h0002);
		for (int i = 0; i < RP + SU + 8 && system_ready_flag !== 1'b1; i++) @(negedge clk);
		check(outs, 16'h0080);
		rchk(16'h8810, 16'h0000);
		rchk(16'h0020, 16'h1bfe);
		// Hardware reset with the strap high and the reset interrupt disabled beforehand
		u_host.wr(16'h0020, 16'h0000);
		power_down_strap_pin = 1'b1;
		hw_reset();
		for (int i = 0; i < SU + 8 && system_ready_flag !== 1'b1; i++) @(negedge clk);
		check(outs, 16'h0091);
		rchk(16'h8818, 16'h0003);
		rchk(16'h8812, 16'h0001);
		rchk(16'h0020, 16'h1bfe);
		u_host.wr(16'h8812, 16'h0000);
		check(outs, 16'h0081);
		rchk(16'h8818, 16'h0001);
		u_host.wr(16'h8812, 16'h0001);
		check(outs, 16'h0091);
		rchk(16'h8812, 16'h0001);
		u_host.wr(16'h8819, 16'h0001);
		rchk(16'h8819, 16'h0001);
		check(outs, 16'h00b1);
		wrap_up();
	end

	// Cut a hang short; the whole sequence needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
